// file: core/pss_pkg.sv
// Purpose: constants, types and register layout of the power state sequencer
// Assumes: 50 MHz clock, APB register access, analog flags arrive asynchronously
// Notes: one aligned 32-bit word per register
//
// Contract
// - battery unless low and rf is higher
// - lost source switches to other one at once
// - autoswitch disable forces the battery input
// - deep power-down keeps selecting, exits on four events
// - armed wake overrides first port pad, pull-up
// - indicators and regulators follow the power state
// - external reset in low power requests power-on
// - deep-sleep exits on six event kinds
// - timer oscillator steps core, analog, then on
// - always-on reset, then oscillator launches sequencer
// - system reset follows core regulator, oscillator, supply
// - boot waits for flash ready
// - rf only power runs the same sequence
// - timer oscillator cannot be stopped by software
// - each regulator has its own enable
// - rtc power-on request is a wake event
// - supply status register shows whole supply setup; the rf_above_bat comparator flag is not among its bits
// - brown-out interrupt below threshold on always-on supply
// - brown-out interrupt uses hysteresis band
// - autoswitch disable at bit 13, resets 0
// - deep power-down wake restarts full reset cycle

package pss_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SEQ_TIME_US = 92;
  localparam int unsigned SEQ_CYC = SEQ_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SEQ_STEPS = 3;
  localparam int unsigned CNT_W = 13;

  localparam logic [11:0] ADDR_POWER_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_SUPPLY_STATUS = 12'h018;

  localparam int unsigned PC_DEEP_POWERDOWN_ENABLE = 1;
  localparam int unsigned PC_SLEEP_FLAG = 8;
  localparam int unsigned PC_DPD_FLAG = 11;
  localparam int unsigned PC_AUTOSWITCH_DIS = 13;
  localparam int unsigned PC_BAT_OFF = 14;
  localparam int unsigned PC_BOD_EN = 15;
  localparam int unsigned PC_WAKE_EN = 16;
  localparam int unsigned PC_RF_WAKE_EN = 17;
  localparam int unsigned PC_TOSC_OFF = 18;
  localparam logic [31:0] PC_WMASK = 32'h0007_E002;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  localparam int unsigned ST_SRC_RF = 0;
  localparam int unsigned ST_BAT_PRES = 1;
  localparam int unsigned ST_RF_PRES = 2;
  localparam int unsigned ST_BAT_HIGH = 3;
  localparam int unsigned ST_BAT_SW = 4;
  localparam int unsigned ST_RF_SW = 5;
  localparam int unsigned ST_BOD = 6;
  localparam int unsigned ST_STATE_LSB = 8;
  localparam int unsigned ST_CAUSE_LSB = 12;
  localparam logic [3:0] CAUSE_RESET = 4'h1;
  localparam logic [3:0] CAUSE_RTC = 4'h2;
  localparam logic [3:0] CAUSE_WAKE = 4'h4;
  localparam logic [3:0] CAUSE_RF = 4'h8;

  typedef enum logic [1:0] {unpowered_state, active_state, deep_sleep_state, deep_pd_state} pss_pwr_e;
  typedef enum logic [1:0] {seq_off, seq_core, seq_analog, seq_on} pss_seq_e;

  typedef struct packed {
    logic bat_present;
    logic bat_above_thr;
    logic rf_present;
    logic rf_above_bat;
    logic aon_below_bod;
    logic aon_above_hyst;
    logic external_reset_n;
    logic external_wake_pin;
    logic rf_field;
    logic rtc_req;
    logic wdt_event;
    logic start_irq;
    logic timer_oscillator;
    logic core_supply_good;
    logic flash_ready;
  } pss_ana_s;

  typedef struct packed {
    logic core_regulator_en;
    logic analog_regulator_en;
    logic deep_pd_indicator;
    logic deep_sleep_indicator;
    logic battery_power_switch;
    logic rf_power_switch;
    logic system_oscillator_en;
    logic timer_oscillator_en;
    logic pad_wake_sel;
    logic pad_pullup;
    logic sys_por_n;
    logic boot_en;
    logic brownout_irq;
  } pss_pwr_s;

  localparam int unsigned N_ANA = $bits(pss_ana_s);

endpackage

// file: core/pss_sequencer.sv
// Purpose: always-on power state sequencer with apb registers
// Assumes: analog comparator flags are asynchronous and pass two flip-flops
// Notes: timer oscillator is sampled, its rising edges pace all state changes
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

module pss_sequencer #(
  parameter int unsigned SEQ_CYC_P = pss_pkg::SEQ_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_sleep_req,
  input wire pss_pkg::pss_ana_s ana_in,
  output pss_pkg::pss_pwr_s pwr
);
  import pss_pkg::*;

  localparam int unsigned STEP_CYC = SEQ_CYC_P / SEQ_STEPS;
  localparam logic [CNT_W-1:0] STEP_CNT = CNT_W'(STEP_CYC);
  // reset and wake pins idle high, so neither the reset level nor the wake edge logic sees a false event
  localparam pss_ana_s SYNC_IDLE = '{external_reset_n: 1'b1, external_wake_pin: 1'b1, default: 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [N_ANA-1:0] sync1;
  logic [N_ANA-1:0] sync2;
  logic [N_ANA-1:0] ana_raw;
  pss_ana_s a;

  assign ana_raw = ana_in;
  assign a = sync2;

  genvar gi;
  generate
    for (gi = 0; gi < N_ANA; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sync1[gi] <= SYNC_IDLE[gi];
          sync2[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1[gi] <= ana_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised levels

  logic tosc_q;
  logic wake_q;
  logic tick;
  logic wake_fall;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tosc_q <= 1'b0;
      wake_q <= 1'b1;
    end else begin
      tosc_q <= a.timer_oscillator;
      wake_q <= a.external_wake_pin;
    end
  end

  assign tick = a.timer_oscillator & ~tosc_q;
  assign wake_fall = wake_q & ~a.external_wake_pin;

  ////////////////////////////////////////////////////////////////////////
  // registers and apb slave

  logic [31:0] power_control_reg;
  logic [31:0] status;
  logic acc;
  logic wr_power_control_reg;
  logic mapped;
  logic [3:0] cause;
  logic set_sleep_flag;
  logic set_dpd_flag;
  logic [31:0] next_power_control_reg;

  assign acc = psel & penable & pready;
  assign wr_power_control_reg = acc & pwrite & (paddr == ADDR_POWER_CONTROL);
  assign mapped = (paddr == ADDR_POWER_CONTROL) | (paddr == ADDR_SUPPLY_STATUS);

  // flags are write-one-to-clear, a set in the same cycle wins
  always_comb begin
    next_power_control_reg = power_control_reg;
    if (wr_power_control_reg) begin
      next_power_control_reg = (power_control_reg & ~PC_WMASK) | (pwdata & PC_WMASK);
      if (pwdata[PC_SLEEP_FLAG]) begin
        next_power_control_reg[PC_SLEEP_FLAG] = 1'b0;
      end
      if (pwdata[PC_DPD_FLAG]) begin
        next_power_control_reg[PC_DPD_FLAG] = 1'b0;
      end
    end
    if (set_sleep_flag) begin
      next_power_control_reg[PC_SLEEP_FLAG] = 1'b1;
    end
    if (set_dpd_flag) begin
      next_power_control_reg[PC_DPD_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_control_reg <= PC_RESET;
    end else begin
      power_control_reg <= next_power_control_reg;
    end
  end

  // zero wait state: answer is prepared in the setup cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      if (pwrite | ~mapped) begin
        prdata <= 32'h0000_0000;
      end else if (paddr == ADDR_POWER_CONTROL) begin
        prdata <= power_control_reg;
      end else begin
        prdata <= status;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source selection, runs in every power state

  logic bat_avail;
  logic next_sel_rf;
  logic sel_rf;
  logic supply_ok;

  assign bat_avail = a.bat_present & ~power_control_reg[PC_BAT_OFF];
  assign supply_ok = bat_avail | a.rf_present | power_control_reg[PC_AUTOSWITCH_DIS];

  always_comb begin
    if (power_control_reg[PC_AUTOSWITCH_DIS]) begin
      next_sel_rf = 1'b0;
    end else if (!bat_avail) begin
      next_sel_rf = a.rf_present;
    end else begin
      next_sel_rf = a.rf_present & ~a.bat_above_thr & a.rf_above_bat;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_rf <= 1'b0;
    end else begin
      sel_rf <= next_sel_rf;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state and wake events

  pss_pwr_e state;
  pss_seq_e seq;
  logic sleep_pend;
  logic wake_pend;
  logic [3:0] wake_cause;
  logic dpd_exit;
  logic ds_evt;
  logic [3:0] dpd_evt;

  // external reset also forces a power-on request in either low power state
  assign dpd_evt[0] = ~a.external_reset_n;
  assign dpd_evt[1] = a.rtc_req;
  assign dpd_evt[2] = wake_fall & power_control_reg[PC_WAKE_EN];
  assign dpd_evt[3] = a.rf_field & power_control_reg[PC_RF_WAKE_EN];
  assign ds_evt = (|dpd_evt) | a.wdt_event | a.start_irq | (wake_fall & power_control_reg[PC_WAKE_EN]);

  // cpu request is a one-cycle pulse, held until the next oscillator edge
  // a pulse on an oscillator edge wins, else it would be lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_pend <= 1'b0;
    end else if (cpu_sleep_req & (state == active_state)) begin
      sleep_pend <= 1'b1;
    end else if (tick) begin
      sleep_pend <= 1'b0;
    end
  end

  // wake events are short, caught here and applied on the oscillator edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_pend <= 1'b0;
      wake_cause <= 4'h0;
    end else if (state == deep_pd_state) begin
      if (|dpd_evt) begin
        wake_pend <= 1'b1;
        wake_cause <= wake_cause | dpd_evt;
      end else if (tick) begin
        wake_pend <= 1'b0;
      end
    end else if (state == deep_sleep_state) begin
      if (ds_evt) begin
        wake_pend <= 1'b1;
      end else if (tick) begin
        wake_pend <= 1'b0;
      end
    end else begin
      wake_pend <= 1'b0;
      wake_cause <= 4'h0;
    end
  end

  assign dpd_exit = tick & wake_pend & (state == deep_pd_state);
  assign set_sleep_flag = tick & sleep_pend & ~power_control_reg[PC_DEEP_POWERDOWN_ENABLE];
  assign set_dpd_flag = tick & sleep_pend & power_control_reg[PC_DEEP_POWERDOWN_ENABLE];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= unpowered_state;
    end else if (tick) begin
      case (state)
        unpowered_state: begin
          if (seq == seq_on) begin
            state <= active_state;
          end
        end
        active_state: begin
          if (!supply_ok) begin
            state <= unpowered_state;
          end else if (sleep_pend) begin
            state <= power_control_reg[PC_DEEP_POWERDOWN_ENABLE] ? deep_pd_state : deep_sleep_state;
          end
        end
        deep_sleep_state: begin
          if (wake_pend) begin
            state <= active_state;
          end
        end
        deep_pd_state: begin
          if (wake_pend) begin
            state <= unpowered_state;
          end
        end
        default: begin
          state <= unpowered_state;
        end
      endcase
    end
  end

  // cause stays readable after the restart until the next deep power-down wake
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause <= 4'h0;
    end else if (dpd_exit) begin
      cause <= wake_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up sequencer paced by the timer oscillator

  logic [CNT_W-1:0] step_cnt;
  logic step_done;

  assign step_done = (step_cnt >= STEP_CNT);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= '0;
    end else if (tick & ((seq == seq_off) | step_done)) begin
      step_cnt <= '0; // spacing counts from the step itself
    end else if (!step_done) begin
      step_cnt <= step_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq <= seq_off;
    end else if (tick) begin
      case (seq)
        seq_off: begin
          if (supply_ok & (state == unpowered_state)) begin
            seq <= seq_core;
          end
        end
        seq_core: begin
          if (!supply_ok) begin
            seq <= seq_off;
          end else if (step_done) begin
            seq <= seq_analog;
          end
        end
        seq_analog: begin
          if (!supply_ok) begin
            seq <= seq_off;
          end else if (step_done) begin
            seq <= seq_on;
          end
        end
        seq_on: begin
          // deep power-down drops the regulators, wake reruns the whole ramp
          if (!supply_ok | (state == deep_pd_state)) begin
            seq <= seq_off;
          end else if (sleep_pend & power_control_reg[PC_DEEP_POWERDOWN_ENABLE] & (state == active_state)) begin
            seq <= seq_off;
          end
        end
        default: begin
          seq <= seq_off;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  logic next_core_en;
  logic next_analog_en;
  logic next_osc_en;
  logic next_por_n;
  logic bod_irq;

  assign next_core_en = (seq != seq_off) & (state != deep_pd_state);
  assign next_analog_en = ((seq == seq_analog) | (seq == seq_on)) &
                          ((state == active_state) | (state == unpowered_state));
  assign next_osc_en = next_core_en;
  assign next_por_n = (seq == seq_on) & next_core_en & next_osc_en & a.core_supply_good;

  // hysteresis: set below threshold, cleared above threshold plus band or when the enable is cleared
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bod_irq <= 1'b0;
    end else if (power_control_reg[PC_BOD_EN] & a.aon_below_bod) begin
      bod_irq <= 1'b1;
    end else if (!power_control_reg[PC_BOD_EN] | a.aon_above_hyst) begin
      bod_irq <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr <= '0;
    end else begin
      pwr.core_regulator_en <= next_core_en;
      pwr.analog_regulator_en <= next_analog_en;
      pwr.deep_pd_indicator <= (state == deep_pd_state);
      pwr.deep_sleep_indicator <= (state == deep_sleep_state);
      pwr.battery_power_switch <= ~sel_rf & (bat_avail | power_control_reg[PC_AUTOSWITCH_DIS]);
      pwr.rf_power_switch <= sel_rf;
      pwr.system_oscillator_en <= next_osc_en;
      pwr.timer_oscillator_en <= 1'b1;
      pwr.pad_wake_sel <= power_control_reg[PC_WAKE_EN] & power_control_reg[PC_DEEP_POWERDOWN_ENABLE];
      pwr.pad_pullup <= power_control_reg[PC_WAKE_EN] & power_control_reg[PC_DEEP_POWERDOWN_ENABLE];
      pwr.sys_por_n <= next_por_n;
      pwr.boot_en <= next_por_n & a.flash_ready;
      pwr.brownout_irq <= bod_irq;
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[ST_SRC_RF] = sel_rf;
    status[ST_BAT_PRES] = a.bat_present;
    status[ST_RF_PRES] = a.rf_present;
    status[ST_BAT_HIGH] = a.bat_above_thr;
    status[ST_BAT_SW] = pwr.battery_power_switch;
    status[ST_RF_SW] = pwr.rf_power_switch;
    status[ST_BOD] = bod_irq;
    status[ST_STATE_LSB +: 2] = state;
    status[ST_STATE_LSB + 2 +: 2] = seq;
    status[ST_CAUSE_LSB +: 4] = cause;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  src_forced_a: assert property (power_control_reg[PC_AUTOSWITCH_DIS] |=> !sel_rf)
    else $error("rf selected while autoswitch disabled");
  src_choice_a: assert property (!power_control_reg[PC_AUTOSWITCH_DIS] && bat_avail && a.bat_above_thr |=> !sel_rf)
    else $error("rf chosen over a healthy battery");
  switch_over_a: assert property (!power_control_reg[PC_AUTOSWITCH_DIS] && !bat_avail && a.rf_present |=> ##1 pwr.rf_power_switch)
    else $error("no switchover to rf");
  ldo_map_a: assert property ($past(state) == deep_sleep_state |-> pwr.core_regulator_en && !pwr.analog_regulator_en
    && pwr.deep_sleep_indicator && !pwr.deep_pd_indicator)
    else $error("deep sleep regulator setting wrong");
  dpd_off_a: assert property (state == deep_pd_state |=> !pwr.core_regulator_en && !pwr.analog_regulator_en
    && pwr.deep_pd_indicator)
    else $error("regulators on in deep power-down");
  seq_on_tick_a: assert property (seq != $past(seq) |-> $past(tick))
    else $error("sequencer moved without oscillator edge");
  dpd_restart_a: assert property (dpd_exit |=> state == unpowered_state ##1 !pwr.sys_por_n)
    else $error("deep power-down wake did not restart");
  boot_hold_a: assert property (pwr.boot_en |-> $past(a.flash_ready) && pwr.sys_por_n)
    else $error("boot without flash ready");
  tosc_run_a: assert property (power_control_reg[PC_TOSC_OFF] |=> pwr.timer_oscillator_en)
    else $error("timer oscillator stopped");
  pad_over_a: assert property (power_control_reg[PC_WAKE_EN] && power_control_reg[PC_DEEP_POWERDOWN_ENABLE] |=> pwr.pad_wake_sel && pwr.pad_pullup)
    else $error("pad not overridden");
  bod_set_a: assert property (power_control_reg[PC_BOD_EN] && a.aon_below_bod |=> ##1 pwr.brownout_irq)
    else $error("brown-out not raised");
  bod_hold_a: assert property (bod_irq && power_control_reg[PC_BOD_EN] && !a.aon_above_hyst |=> bod_irq)
    else $error("brown-out dropped inside band");
  rst_wake_a: assert property (state == deep_sleep_state && !a.external_reset_n |=> wake_pend)
    else $error("external reset did not request power-on");

endmodule

// file: sim/pss_ana_model.sv
// Purpose: stand-in for the analog side: timer oscillator, core supply, flash
// Assumes: bench drives comparator and event levels through ctl
// Notes: oscillator period 8 clocks keeps the power-up short
`timescale 1ns/100ps

module pss_ana_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire pss_pkg::pss_ana_s ctl,
  input wire pss_pkg::pss_pwr_s pwr,
  output pss_pkg::pss_ana_s ana
);
  import pss_pkg::*;
  logic [2:0] div;
  logic [3:0] core_dly;
  logic [3:0] por_dly;
  ////////////////////////////////////////////////////////////
  // runs from always-on reset, no software stop reaches it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div <= 3'h0;
    end else begin
      div <= div + 3'h1;
    end
  end
  // supply lags its own regulator enable, drops when it goes off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_dly <= 4'h0;
    end else begin
      core_dly <= {core_dly[2:0], pwr.core_regulator_en};
    end
  end
  // flash becomes ready some cycles after system reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      por_dly <= 4'h0;
    end else begin
      por_dly <= {por_dly[2:0], pwr.sys_por_n};
    end
  end
  ////////////////////////////////////////////////////////////
  // rtc request passes straight through
  always_comb begin
    ana = ctl;
    ana.timer_oscillator = div[2];
    ana.core_supply_good = core_dly[3];
    ana.flash_ready = por_dly[3];
  end
endmodule

// file: sim/tb_top.sv
// Purpose: self-checking bench of the power state sequencer
// Assumes: short sequencer count, fast timer oscillator from the model
// Notes: every scenario is one task that judges its own results
`timescale 1ns/100ps

module tb_top;
  import pss_pkg::*;
  localparam int unsigned SEQ_P = 30;
  localparam int LIMIT = 20000;
  logic clock, rst_n, psel, penable, pwrite, cpu_sleep_req, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pss_ana_s ctl, ana;
  pss_pwr_s pwr;
  int bad_count, num_checks, cyc, n;
  logic [4:0] src_tab [5] = '{5'b11000, 5'b11100, 5'b10111, 5'b00111, 5'b11100};
  logic [3:0] cause_tab [4] = '{CAUSE_RESET, CAUSE_RTC, CAUSE_WAKE, CAUSE_RF};

  pss_sequencer #(.SEQ_CYC_P(SEQ_P)) DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_sleep_req(cpu_sleep_req), .ana_in(ana), .pwr(pwr));
  pss_ana_model ANA (.clock(clock), .rst_n(rst_n), .ctl(ctl), .pwr(pwr), .ana(ana));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sleep_go();
    @(posedge clock);
    cpu_sleep_req <= 1'b1;
    @(posedge clock);
    cpu_sleep_req <= 1'b0;
  endtask

  // 0 reset, 1 rtc, 2 wake pin low, 3 rf field, 4 watchdog, 5 start logic
  task automatic fire(input int k, input logic on);
    @(posedge clock);
    case (k)
      0: ctl.external_reset_n <= !on;
      1: ctl.rtc_req <= on;
      2: ctl.external_wake_pin <= !on;
      3: ctl.rf_field <= on;
      4: ctl.wdt_event <= on;
      default: ctl.start_irq <= on;
    endcase
  endtask

  task automatic wait_active();
    for (n = 0; n < 600 && !(pwr.boot_en === 1'b1 && pwr.analog_regulator_en === 1'b1); n++) @(posedge clock);
    repeat (12) @(posedge clock);
    apb(1'b0, ADDR_SUPPLY_STATUS, 32'h0);
    chk("state active", rd[9:8], 2'h1);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, ADDR_POWER_CONTROL, 32'h0);
    chk("control reset", rd, PC_RESET);
    apb(1'b0, ADDR_SUPPLY_STATUS, 32'h0);
    chk("off after reset", rd[11:8], 4'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped error", {rd[30:0], err}, 32'h1);
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0004_2000);
    apb(1'b0, ADDR_POWER_CONTROL, 32'h0);
    chk("autoswitch bit", rd[13], 1'b1);
    chk("osc stop ignored", pwr.timer_oscillator_en, 1'b1);
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0);
    // a start made under forced battery must fall back to off first
    repeat (20) @(posedge clock);
    $display("done reset");
  endtask

  task automatic t_powerup();
    @(posedge clock);
    ctl.bat_present <= 1'b1;
    ctl.bat_above_thr <= 1'b1;
    for (n = 0; n < 300 && pwr.core_regulator_en !== 1'b1; n++) @(posedge clock);
    chk("analog after core", pwr.analog_regulator_en, 1'b0);
    chk("por held", pwr.sys_por_n, 1'b0);
    chk("osc with core", pwr.system_oscillator_en, 1'b1);
    for (n = 0; n < 300 && pwr.analog_regulator_en !== 1'b1; n++) @(posedge clock);
    chk("step spacing", n >= SEQ_P / 3 - 1, 1'b1);
    for (n = 0; n < 300 && pwr.boot_en !== 1'b1; n++) @(posedge clock);
    chk("por released", pwr.sys_por_n, 1'b1);
    chk("battery used", {pwr.battery_power_switch, pwr.rf_power_switch}, 2'b10);
    wait_active();
    $display("done powerup");
  endtask

  task automatic t_source();
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      {ctl.bat_present, ctl.bat_above_thr, ctl.rf_present, ctl.rf_above_bat} <= src_tab[i][4:1];
      repeat (6) @(posedge clock);
      chk("switches", {pwr.battery_power_switch, pwr.rf_power_switch}, {!src_tab[i][0], src_tab[i][0]});
      apb(1'b0, ADDR_SUPPLY_STATUS, 32'h0);
      chk("status source", rd[5:0], {src_tab[i][0], !src_tab[i][0], src_tab[i][3], src_tab[i][2],
        src_tab[i][4], src_tab[i][0]});
    end
    {ctl.bat_present, ctl.bat_above_thr, ctl.rf_present, ctl.rf_above_bat} <= 4'b1011;
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0000_2000);
    repeat (6) @(posedge clock);
    chk("forced battery", {pwr.battery_power_switch, pwr.rf_power_switch}, 2'b10);
    {ctl.bat_present, ctl.bat_above_thr, ctl.rf_present, ctl.rf_above_bat} <= 4'b1110;
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0000_4000);
    repeat (6) @(posedge clock);
    chk("battery off", {pwr.battery_power_switch, pwr.rf_power_switch}, 2'b01);
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0);
    repeat (6) @(posedge clock);
    $display("done source");
  endtask

  task automatic t_sleep();
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0003_0000);
    for (int k = 0; k < 6; k++) begin
      sleep_go();
      for (n = 0; n < 100 && pwr.deep_sleep_indicator !== 1'b1; n++) @(posedge clock);
      chk("deep sleep regs", pwr[12:9], 4'b1001);
      fire(k, 1'b1);
      for (n = 0; n < 300 && pwr.deep_sleep_indicator !== 1'b0; n++) @(posedge clock);
      fire(k, 1'b0);
      chk("sleep exit", n < 300, 1'b1);
      wait_active();
    end
    $display("done sleep");
  endtask

  task automatic t_deeppd();
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0001_0000);
    repeat (4) @(posedge clock);
    chk("no pad override", pwr.pad_wake_sel, 1'b0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_POWER_CONTROL, 32'h0003_0802);
      repeat (4) @(posedge clock);
      chk("pad override", {pwr.pad_wake_sel, pwr.pad_pullup}, 2'b11);
      sleep_go();
      for (n = 0; n < 100 && pwr.deep_pd_indicator !== 1'b1; n++) @(posedge clock);
      chk("deep pd regs", pwr[12:9], 4'b0010);
      fire(4, 1'b1);
      {ctl.bat_above_thr, ctl.rf_above_bat} <= 2'b01;
      repeat (40) @(posedge clock);
      chk("stays in deep pd", pwr.deep_pd_indicator, 1'b1);
      chk("selects in deep pd", pwr.rf_power_switch, 1'b1);
      fire(4, 1'b0);
      {ctl.bat_above_thr, ctl.rf_above_bat} <= 2'b10;
      fire(k, 1'b1);
      for (n = 0; n < 300 && pwr.deep_pd_indicator !== 1'b0; n++) @(posedge clock);
      chk("full reset", pwr.sys_por_n, 1'b0);
      fire(k, 1'b0);
      wait_active();
      chk("exit cause", rd[15:12], cause_tab[k]);
    end
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0000_0800);
    $display("done deep pd");
  endtask

  task automatic t_bod();
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0000_8000);
    {ctl.aon_below_bod, ctl.aon_above_hyst} <= 2'b10;
    repeat (6) @(posedge clock);
    chk("bod set", pwr.brownout_irq, 1'b1);
    {ctl.aon_below_bod, ctl.aon_above_hyst} <= 2'b00;
    repeat (6) @(posedge clock);
    chk("bod in band", pwr.brownout_irq, 1'b1);
    ctl.aon_above_hyst <= 1'b1;
    repeat (6) @(posedge clock);
    chk("bod cleared", pwr.brownout_irq, 1'b0);
    apb(1'b1, ADDR_POWER_CONTROL, 32'h0);
    {ctl.aon_below_bod, ctl.aon_above_hyst} <= 2'b10;
    repeat (6) @(posedge clock);
    chk("bod disabled", pwr.brownout_irq, 1'b0);
    {ctl.aon_below_bod, ctl.aon_above_hyst} <= 2'b01;
    $display("done brownout");
  endtask

  task automatic t_rfonly();
    @(posedge clock);
    rst_n <= 1'b0;
    {ctl.bat_present, ctl.bat_above_thr, ctl.rf_present, ctl.rf_above_bat} <= 4'b0011;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    for (n = 0; n < 300 && pwr.core_regulator_en !== 1'b1; n++) @(posedge clock);
    chk("rf feeds regs", {pwr.battery_power_switch, pwr.rf_power_switch}, 2'b01);
    wait_active();
    $display("done rf only");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      results();
    end
  end

  initial begin
    {psel, penable, pwrite, cpu_sleep_req} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ctl = '0;
    ctl.external_reset_n = 1'b1;
    ctl.external_wake_pin = 1'b1;
    ctl.aon_above_hyst = 1'b1;
    {bad_count, num_checks, cyc} = '0;
    rst_n = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_powerup();
    t_source();
    t_sleep();
    t_deeppd();
    t_bod();
    t_rfonly();
    results();
  end
endmodule
